//--- verilog/stm_timer.sv
// module: 16-bit standard timer with compare, pwm and avalon register slave
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - compare mode pin starts at level bit
// - level bit sets pwm active polarity
// - single pulse: on rise drives level bit
// - timer/counter mode ignores level and invert
// - invert bit flips output pin
// - swap bit exchanges period and duty compares
// - clear select picks compare a or p
// - compare p on top byte, zero overflows
// - clear select ignored outside compare modes
// - mode field selects operating mode
// - clear select low sets both flags
// - clear select high in compare modes never sets p flag
// - compare a zero: overflow, no a flag
// - compare mode: only compare a match moves pin
// - pin action: none, low, high, toggle
// - counter on rise restores initial pin level
// - on rise clears count, fall holds it
// - timer/counter like compare, pin undriven
// - pwm mode sets both match flags
// - pwm pin enabled or forced fixed
// - pwm pin action: inactive, active, pwm, pulse
module stm_timer import stm_pkg::*; (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output var logic [31:0] readdata,
   output var logic waitrequest,
   input wire logic ext_clk_pin,
   output var logic timer_output_pin,
   output var logic timer_output_pin_oe
);
   // ----------------------------------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------------------------------
   logic rst_meta_q, rst_n_q;
   logic ext_meta_q, ext_sync_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
      end else begin
         ext_meta_q <= ext_clk_pin;
         ext_sync_q <= ext_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // state declarations
   // ----------------------------------------------------------------
   stm_bus_t bus_q, bus_d;
   logic [31:0] rdata_q, rdata_d;
   logic [7:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d, cmpp_q, cmpp_d;
   logic [15:0] cmpa_q, cmpa_d, cnt_q, cnt_d;
   logic [1:0] flag_q, flag_d;
   logic pin_q, pin_d, on_prev_q, on_prev_d;
   logic out_q, out_d, oe_q, oe_d;
   logic wr_en;
   logic [7:0] rd_mux;
   stm_mode_t mode;
   logic [1:0] pio;
   logic on, pause, olc, inv, dpx, cclr;
   logic on_rise, run, hit_a, hit_p, clr, set_p, single;
   logic cmp_like, pwm_act, raw;
   logic [16:0] inc, p_top, duty_top;

   stm_tick_if tif();

   assign tif.sel = ctrl0_q[C0_CLK_HI:C0_CLK_LO];
   assign tif.ext_level = ext_sync_q;

   stm_tick_gen u_tick (
      .clock(clock),
      .rst_n(rst_n_q),
      .tk(tif.gen)
   );

   // ----------------------------------------------------------------
   // field decode
   // ----------------------------------------------------------------
   assign mode = stm_mode_t'(ctrl1_q[C1_MODE_HI:C1_MODE_LO]);
   assign pio = ctrl1_q[C1_PIO_HI:C1_PIO_LO];
   assign olc = ctrl1_q[C1_OLC];
   assign inv = ctrl1_q[C1_INV];
   assign dpx = ctrl1_q[C1_DPX];
   assign cclr = ctrl1_q[C1_CCLR];
   assign on = ctrl0_q[C0_ON];
   assign pause = ctrl0_q[C0_PAUSE];
   assign cmp_like = (mode == MODE_CMP) || (mode == MODE_TC);
   assign single = (mode == MODE_PWM) && (pio == 2'b11);

   // ----------------------------------------------------------------
   // avalon slave: one wait state, then answer
   // ----------------------------------------------------------------
   assign waitrequest = (read | write) & (bus_q != BUS_ACK);
   assign wr_en = write & ~waitrequest & byteenable[0];
   assign readdata = rdata_q;

   always_comb begin
      unique case (address)
         OFS_CTRL0: rd_mux = ctrl0_q;
         OFS_CTRL1: rd_mux = ctrl1_q;
         OFS_CNT_LO: rd_mux = cnt_q[7:0];
         OFS_CNT_HI: rd_mux = cnt_q[15:8];
         OFS_CMPA_LO: rd_mux = cmpa_q[7:0];
         OFS_CMPA_HI: rd_mux = cmpa_q[15:8];
         OFS_CMPP: rd_mux = cmpp_q;
         OFS_STAT: rd_mux = {6'h00, flag_q};
         default: rd_mux = 8'h00;
      endcase
   end

   always_comb begin
      bus_d = BUS_IDLE;
      rdata_d = rdata_q;
      if ((bus_q == BUS_IDLE) && (read | write)) begin
         bus_d = BUS_ACK;
         if (read) begin
            rdata_d = {24'h000000, rd_mux};
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bus_q <= BUS_IDLE;
         rdata_q <= 32'h00000000;
      end else begin
         bus_q <= bus_d;
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // counter, comparators, flags and pin
   // ----------------------------------------------------------------
   always_comb begin
      on_rise = on & ~on_prev_q;
      run = on & ~pause & tif.tick;
      inc = {1'b0, cnt_q} + 17'h00001;
      p_top = (cmpp_q == 8'h00) ? P_TOP_ZERO : {1'b0, cmpp_q, 8'h00};
      hit_a = run & (cmpa_q != 16'h0000) & (inc == {1'b0, cmpa_q});
      hit_p = run & (inc == p_top);
      duty_top = dpx ? p_top : {1'b0, cmpa_q};
      pwm_act = ({1'b0, cnt_q} < duty_top);
      unique case (mode)
         MODE_PWM: clr = single ? 1'b0 : (dpx ? hit_a : hit_p);
         MODE_CAP: clr = hit_p;
         default: clr = cclr ? hit_a : hit_p;
      endcase
      set_p = hit_p & ~(cmp_like & cclr);
      on_prev_d = on;
      cnt_d = cnt_q;
      if (on_rise) begin
         cnt_d = CNT_RST;
      end else if (run) begin
         cnt_d = clr ? CNT_RST : inc[15:0];
      end
      pin_d = pin_q;
      if (on_rise) begin
         pin_d = olc;
      end else if ((mode == MODE_CMP) && hit_a) begin
         unique case (pio)
            2'b00: pin_d = pin_q;
            2'b01: pin_d = 1'b0;
            2'b10: pin_d = 1'b1;
            2'b11: pin_d = ~pin_q;
         endcase
      end else if (single && (hit_a || (!on && on_prev_q))) begin
         pin_d = ~olc;
      end
      unique case (mode)
         MODE_CMP: raw = pin_q;
         MODE_PWM: begin
            unique case (pio)
               2'b00: raw = ~olc;
               2'b01: raw = olc;
               2'b10: raw = pwm_act ? olc : ~olc;
               2'b11: raw = pin_q;
            endcase
         end
         default: raw = 1'b0;
      endcase
      oe_d = (mode == MODE_CMP) || (mode == MODE_PWM);
      out_d = (raw ^ inv) & oe_d;
   end

   // ----------------------------------------------------------------
   // register file writes; hardware set wins over software clear
   // ----------------------------------------------------------------
   always_comb begin
      ctrl0_d = ctrl0_q;
      ctrl1_d = ctrl1_q;
      cmpa_d = cmpa_q;
      cmpp_d = cmpp_q;
      flag_d = flag_q;
      if (single && hit_a) begin
         ctrl0_d[C0_ON] = 1'b0;
      end
      if (wr_en) begin
         unique case (address)
            OFS_CTRL0: ctrl0_d = writedata[7:0] & C0_WMASK;
            OFS_CTRL1: ctrl1_d = writedata[7:0];
            OFS_CMPA_LO: cmpa_d[7:0] = writedata[7:0];
            OFS_CMPA_HI: cmpa_d[15:8] = writedata[7:0];
            OFS_CMPP: cmpp_d = writedata[7:0];
            OFS_STAT: flag_d = flag_q & ~writedata[1:0];
            default: flag_d = flag_q;
         endcase
      end
      flag_d[ST_A] = flag_d[ST_A] | hit_a;
      flag_d[ST_P] = flag_d[ST_P] | set_p;
   end

   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ctrl0_q <= CTRL0_RST;
         ctrl1_q <= CTRL1_RST;
         cmpa_q <= CMPA_RST;
         cmpp_q <= CMPP_RST;
         cnt_q <= CNT_RST;
         flag_q <= 2'b00;
         pin_q <= 1'b0;
         on_prev_q <= 1'b0;
         out_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         ctrl0_q <= ctrl0_d;
         ctrl1_q <= ctrl1_d;
         cmpa_q <= cmpa_d;
         cmpp_q <= cmpp_d;
         cnt_q <= cnt_d;
         flag_q <= flag_d;
         pin_q <= pin_d;
         on_prev_q <= on_prev_d;
         out_q <= out_d;
         oe_q <= oe_d;
      end
   end

   assign timer_output_pin = out_q;
   assign timer_output_pin_oe = oe_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n_q);

   on_rise_clr_a: assert property (on_rise |=> cnt_q == 16'h0000)
      else $error("counter not cleared on enable rise");
   pin_init_a: assert property (on_rise |=> pin_q == $past(olc))
      else $error("pin not restored to initial level");
   cmp_out_a: assert property ((mode == MODE_CMP) ##1 (mode == MODE_CMP)
      |-> timer_output_pin == ($past(pin_q) ^ $past(inv)))
      else $error("compare mode pin level wrong");
   tc_quiet_a: assert property ((mode == MODE_TC) |=>
      (!timer_output_pin && !timer_output_pin_oe))
      else $error("timer/counter mode drives pin");
   no_pflag_a: assert property ((cmp_like && cclr && !flag_q[ST_P]
      && !(wr_en && address == OFS_CTRL1)) |=> !flag_q[ST_P])
      else $error("p flag set with clear select high");
   zero_a_a: assert property ((cmpa_q == 16'h0000 && !flag_q[ST_A]
      && !wr_en) |=> !flag_q[ST_A])
      else $error("a flag set with compare a zero");
   pause_hold_a: assert property ((on && pause && !on_rise) |=>
      $stable(cnt_q))
      else $error("counter moved while paused");
   count_inc_a: assert property ((run && !clr && !on_rise) |=>
      cnt_q == $past(cnt_q) + 16'h0001)
      else $error("counter did not increment");
   clear_p_a: assert property ((cmp_like && !cclr && hit_p && !on_rise)
      |=> (cnt_q == 16'h0000) && flag_q[ST_P])
      else $error("compare p match did not clear");
   swap_clr_a: assert property ((mode == MODE_PWM && !single && dpx
      && hit_a && !on_rise) |=> cnt_q == 16'h0000)
      else $error("swapped period not cleared by compare a");
   act_a_a: assert property ((mode == MODE_CMP && hit_a && !on_rise
      && pio == 2'b01) |=> !pin_q ##1 !timer_output_pin == !inv)
      else $error("drive low action failed");
   force_a: assert property ((mode == MODE_PWM && pio == 2'b01)
      |=> timer_output_pin == ($past(olc) ^ $past(inv)))
      else $error("forced active level wrong");
   bus_wait_a: assert property (((read || write) && bus_q == BUS_IDLE)
      |-> waitrequest ##1 !waitrequest)
      else $error("bus answer not after one wait");
   inactive_a: assert property ((mode == MODE_PWM && pio == 2'b00)
      |=> timer_output_pin == (!$past(olc) ^ $past(inv)))
      else $error("forced inactive level wrong");
   pwm_oe_a: assert property ((mode == MODE_PWM) |=>
      timer_output_pin_oe)
      else $error("pwm mode does not drive pin");
   pulse_end_a: assert property ((single && hit_a && !on_rise && !wr_en)
      |=> !on && (pin_q == !$past(olc)))
      else $error("single pulse did not end on compare a");
   flag_a_set_a: assert property (hit_a |=> flag_q[ST_A])
      else $error("a flag not set on compare a match");
   flag_p_set_a: assert property (set_p |=> flag_q[ST_P])
      else $error("p flag not set on compare p match");
   pwm_p_clr_a: assert property ((mode == MODE_PWM && !single && !dpx
      && hit_p && !on_rise) |=> cnt_q == 16'h0000)
      else $error("pwm period not cleared by compare p");
   clear_a_a: assert property ((cmp_like && cclr && hit_a && !on_rise)
      |=> cnt_q == 16'h0000)
      else $error("compare a match did not clear");

   cmp_toggle_c: cover property (mode == MODE_CMP && hit_a && pio == 2'b11);
   pwm_wave_c: cover property (mode == MODE_PWM && pio == 2'b10 && hit_p);
   single_c: cover property (single && hit_a);
   tc_flag_c: cover property (mode == MODE_TC && hit_p);
endmodule
`default_nettype wire

//--- verilog/stm_pkg.sv
// package: register map, fields, resets and modes of the standard timer
package stm_pkg;
   localparam logic [4:0] OFS_CTRL0 = 5'h00;
   localparam logic [4:0] OFS_CTRL1 = 5'h04;
   localparam logic [4:0] OFS_CNT_LO = 5'h08;
   localparam logic [4:0] OFS_CNT_HI = 5'h0c;
   localparam logic [4:0] OFS_CMPA_LO = 5'h10;
   localparam logic [4:0] OFS_CMPA_HI = 5'h14;
   localparam logic [4:0] OFS_CMPP = 5'h18;
   localparam logic [4:0] OFS_STAT = 5'h1c;
   localparam int C0_PAUSE = 7;
   localparam int C0_CLK_HI = 6;
   localparam int C0_CLK_LO = 4;
   localparam int C0_ON = 3;
   localparam logic [7:0] C0_WMASK = 8'hf8;
   localparam int C1_MODE_HI = 7;
   localparam int C1_MODE_LO = 6;
   localparam int C1_PIO_HI = 5;
   localparam int C1_PIO_LO = 4;
   localparam int C1_OLC = 3;
   localparam int C1_INV = 2;
   localparam int C1_DPX = 1;
   localparam int C1_CCLR = 0;
   localparam int ST_A = 0;
   localparam int ST_P = 1;
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CMPA_RST = 16'h0000;
   localparam logic [7:0] CMPP_RST = 8'h00;
   localparam logic [16:0] P_TOP_ZERO = 17'h10000;
   localparam logic [7:0] DIV_SYS4 = 8'h03;
   localparam logic [7:0] DIV_H16 = 8'h0f;
   localparam logic [7:0] DIV_H64 = 8'h3f;
   localparam logic [7:0] DIV_SUB = 8'hff;
   typedef enum logic [1:0] {
      MODE_CMP = 2'b00,
      MODE_CAP = 2'b01,
      MODE_PWM = 2'b10,
      MODE_TC = 2'b11
   } stm_mode_t;
   typedef enum logic {BUS_IDLE, BUS_ACK} stm_bus_t;
endpackage

//--- verilog/stm_tick_if.sv
// interface: clock select request and timer tick between core and prescaler
`timescale 1ns/100ps
`default_nettype none
interface stm_tick_if;
   logic [2:0] sel;
   logic ext_level;
   logic tick;
   modport gen (input sel, input ext_level, output tick);
   modport use_side (output sel, output ext_level, input tick);
endinterface
`default_nettype wire

//--- verilog/stm_tick_gen.sv
// module: timer clock prescaler and external edge tick source
`timescale 1ns/100ps
`default_nettype none
module stm_tick_gen import stm_pkg::*; (
   input wire logic clock,
   input wire logic rst_n,
   stm_tick_if.gen tk
);
   logic [7:0] pre_q, pre_d;
   logic ext_prev_q, ext_prev_d;

   always_comb begin
      pre_d = pre_q + 8'h01;
      ext_prev_d = tk.ext_level;
      unique case (tk.sel)
         3'b000: tk.tick = (pre_q[1:0] == DIV_SYS4[1:0]);
         3'b001: tk.tick = 1'b1;
         3'b010: tk.tick = (pre_q[3:0] == DIV_H16[3:0]);
         3'b011: tk.tick = (pre_q[5:0] == DIV_H64[5:0]);
         3'b100, 3'b101: tk.tick = (pre_q == DIV_SUB);
         3'b110: tk.tick = tk.ext_level & ~ext_prev_q;
         3'b111: tk.tick = ~tk.ext_level & ext_prev_q;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= 8'h00;
         ext_prev_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         ext_prev_q <= ext_prev_d;
      end
   end
endmodule
`default_nettype wire

//--- verif/stm_timer_tb.sv
// testbench: register, compare, timer/counter and pwm checks of the timer
`timescale 1ns/100ps
`default_nettype none
module tb import stm_pkg::*;;
   localparam int LIMIT = 30000;
   logic clock;
   logic arst_n;
   logic [4:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [3:0] byteenable;
   logic [31:0] readdata;
   logic waitrequest;
   logic ext_clk_pin;
   logic timer_output_pin;
   logic timer_output_pin_oe;
   int failures;
   int samples_checked;
   int seed;
   int cycles;
   logic [7:0] exp_q[$];

   stm_timer u_dut (
      .clock(clock),
      .arst_n(arst_n),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .byteenable(byteenable),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .ext_clk_pin(ext_clk_pin),
      .timer_output_pin(timer_output_pin),
      .timer_output_pin_oe(timer_output_pin_oe)
   );

   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic wrap_up();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(logic wr, logic [4:0] a, logic [7:0] d);
      @(posedge clock);
      address <= a;
      writedata <= {24'h0, d};
      byteenable <= 4'h1;
      if (wr) write <= 1'b1;
      else read <= 1'b1;
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic rd(logic [4:0] a, logic [7:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask

   // restart the counter at every clock with the given control
   task automatic setup(logic [15:0] a, logic [7:0] p, logic [7:0] c1);
      bus(1'b1, OFS_CTRL0, 8'h00);
      bus(1'b1, OFS_CMPA_LO, a[7:0]);
      bus(1'b1, OFS_CMPA_HI, a[15:8]);
      bus(1'b1, OFS_CMPP, p);
      bus(1'b1, OFS_CTRL1, c1);
      bus(1'b1, OFS_STAT, 8'h03);
      bus(1'b1, OFS_CTRL0, 8'h18);
   endtask

   task automatic pin(logic oe, logic e);
      chk("pin_oe", {31'h0, timer_output_pin_oe}, {31'h0, oe});
      chk("pin", {31'h0, timer_output_pin}, {31'h0, e});
   endtask

   task automatic highs(int n, int e);
      int c;
      c = 0;
      repeat (8) @(posedge clock);
      repeat (n) begin
         @(posedge clock);
         c += int'(timer_output_pin === 1'b1);
      end
      chk("high_cycles", c, e);
   endtask

   always @(posedge clock) begin
      if (read === 1'b1 && waitrequest === 1'b0) begin
         if (exp_q.size() == 0) chk("stray_read", 32'h1, 32'h0);
         else chk("readdata", readdata, {24'h0, exp_q.pop_front()});
      end
   end

   always @(posedge clock) begin
      ext_clk_pin <= 1'($random(seed));
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         wrap_up();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0] v;
      logic [3:0] m;
      logic e;
      seed = 50111;
      arst_n = 1'b0;
      address = 5'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'h0;
      ext_clk_pin = 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      for (int i = 0; i < 8; i++) rd(5'(i * 4), 8'h00);
      rd(5'h02, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         bus(1'b1, OFS_CMPA_LO, v);
         bus(1'b1, OFS_CMPA_HI, ~v);
         bus(1'b1, OFS_CMPP, v ^ 8'h5a);
         bus(1'b1, OFS_CNT_LO, v);
         rd(OFS_CMPA_LO, v);
         rd(OFS_CMPA_HI, ~v);
         rd(OFS_CMPP, v ^ 8'h5a);
         rd(OFS_CNT_LO, 8'h00);
      end
      $display("test register access done");
      for (int i = 0; i < 16; i++) begin
         m = 4'(i);
         setup(16'h0014, 8'h00, {2'b00, m, 2'b00});
         repeat (4) @(posedge clock);
         pin(1'b1, m[1] ^ m[0]);
         case (m[3:2])
            2'b00: e = m[1];
            2'b01: e = 1'b0;
            2'b10: e = 1'b1;
            default: e = ~m[1];
         endcase
         repeat (40) @(posedge clock);
         pin(1'b1, e ^ m[0]);
         rd(OFS_STAT, 8'h01);
      end
      $display("test compare pin actions done");
      setup(16'h0000, 8'h00, 8'h00);
      repeat (100) @(posedge clock);
      rd(OFS_STAT, 8'h00);
      bus(1'b1, OFS_CTRL0, 8'h00);
      bus(1'b1, OFS_CTRL0, 8'h98);
      repeat (20) @(posedge clock);
      rd(OFS_CNT_LO, 8'h00);
      rd(OFS_CNT_HI, 8'h00);
      setup(16'h0014, 8'h01, 8'h00);
      repeat (300) @(posedge clock);
      rd(OFS_STAT, 8'h03);
      setup(16'h012c, 8'h01, 8'h00);
      repeat (400) @(posedge clock);
      rd(OFS_STAT, 8'h02);
      setup(16'h012c, 8'h01, 8'h01);
      repeat (400) @(posedge clock);
      rd(OFS_STAT, 8'h01);
      setup(16'h0014, 8'h00, 8'hfd);
      repeat (40) @(posedge clock);
      pin(1'b0, 1'b0);
      rd(OFS_STAT, 8'h01);
      $display("test flags and clearing done");
      setup(16'h0040, 8'h01, 8'ha9);
      highs(512, 128);
      rd(OFS_STAT, 8'h03);
      setup(16'h0040, 8'h01, 8'had);
      highs(512, 384);
      setup(16'h0300, 8'h01, 8'ha2);
      highs(1536, 1024);
      setup(16'h0040, 8'h01, 8'h88);
      highs(256, 0);
      setup(16'h0040, 8'h01, 8'h98);
      highs(256, 256);
      setup(16'h0014, 8'h00, 8'hb8);
      repeat (4) @(posedge clock);
      pin(1'b1, 1'b1);
      repeat (40) @(posedge clock);
      pin(1'b1, 1'b0);
      rd(OFS_CTRL0, 8'h10);
      $display("test pwm and pulse done");
      repeat (4) @(posedge clock);
      wrap_up();
   end
endmodule
`default_nettype wire
